// [core/stsp_ctrl.sv]
// Star-trigger and sync line port controller with register port
// Contract
// - System slot feeds one star pair per slot
// - Each star pair both receives and drives
// - Star driver has its own enable control
// - Star driver off at reset until both enable
// - Star trigger sensed active high, rising edge
// - Received star trigger sense is invertible
// - Only system module drives sync line
// - Sync driver has an enable control
// - Sync driver off until shelf manager enables
// - Software selects sync source once authorised
// - Sync output mode async or reference aligned
// - Sync mode updates/samples at reference rising edge
// - Sync line sensed active high, rising edge
// - Received sync sense is invertible
// - Reference clock is 100 MHz, 100 ppm
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Two-flop synchroniser
// ----------------------------------------
module stsp_sync2 #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_r <= '0;
			q_out  <= '0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule

// ----------------------------------------
// Top level
// ----------------------------------------
module stsp_ctrl
	import stsp_pkg::*;
#(
	parameter int STAR_N = STSP_STAR_CH
) (
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	input  wire stsp_bus_req_t          bus_req,
	output logic      [STSP_DATA_W-1:0] bus_rdata,
	input  wire logic                   role_system_strap,
	input  wire logic [STAR_N-1:0]      shelf_star_auth,
	input  wire logic                   shelf_sync_auth,
	input  wire logic [STAR_N-1:0]      star_trigger_pair_in,
	output logic      [STAR_N-1:0]      star_trigger_pair_out,
	output logic      [STAR_N-1:0]      star_trigger_pair_oe_n,
	input  wire logic                   sync_line_in,
	output logic                        sync_line_out,
	output logic                        sync_line_oe_n,
	input  wire logic                   instr_ref_clock,
	input  wire logic [STAR_N-1:0]      trig_star_src,
	input  wire logic                   trig_sync_src,
	output logic      [STAR_N-1:0]      star_rx,
	output logic      [STAR_N-1:0]      star_rx_rise,
	output logic                        sync_rx,
	output logic                        sync_rx_rise
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int SYNC_W = 2 * STAR_N + 4;

	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] pin_s;
	logic [STAR_N-1:0] star_in_s;
	logic [STAR_N-1:0] star_auth_s;
	logic              sync_in_s;
	logic              sync_auth_s;
	logic              ref_s;
	logic              role_s;

	assign pin_raw = {star_trigger_pair_in, shelf_star_auth, sync_line_in,
		shelf_sync_auth, instr_ref_clock, role_system_strap};

	stsp_sync2 #(.W(SYNC_W)) u_pin_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.d_in    (pin_raw),
		.q_out   (pin_s)
	);

	assign {star_in_s, star_auth_s, sync_in_s, sync_auth_s, ref_s, role_s} = pin_s;

	// ----------------------------------------
	// Role strap, caught once after release
	// ----------------------------------------
	logic [1:0] settle_r;
	logic       role_sys_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			settle_r   <= 2'h0;
			role_sys_r <= 1'b0;
		end else if (settle_r != 2'(STSP_STRAP_SETTLE)) begin
			// Wait for the synchroniser to fill before trusting the strap
			settle_r   <= settle_r + 2'h1;
			role_sys_r <= role_s;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	stsp_sync_cfg_t    sync_cfg_r;
	logic [STAR_N-1:0] star_en_r;
	logic [STAR_N-1:0] star_src_r;
	logic [STAR_N-1:0] star_val_r;
	logic [STAR_N-1:0] star_inv_r;
	logic              wr_ctrl;
	logic              wr_star_en;

	assign wr_ctrl    = bus_req.wr && (bus_req.addr == STSP_OFF_CTRL);
	assign wr_star_en = bus_req.wr && (bus_req.addr == STSP_OFF_STAR_EN);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sync_cfg_r <= '{drv_en: 1'b0, mode: STSP_MODE_ASYNC, src_int: 1'b0,
				sw_val: 1'b0, rx_inv: 1'b0};
		end else if (wr_ctrl) begin
			sync_cfg_r.drv_en  <= bus_req.wdata[STSP_CTRL_DRV_EN];
			sync_cfg_r.mode    <= stsp_sync_mode_t'(bus_req.wdata[STSP_CTRL_MODE]);
			sync_cfg_r.src_int <= bus_req.wdata[STSP_CTRL_SRC_INT];
			sync_cfg_r.sw_val  <= bus_req.wdata[STSP_CTRL_SW_VAL];
			sync_cfg_r.rx_inv  <= bus_req.wdata[STSP_CTRL_RX_INV];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			star_en_r  <= STSP_RST_WORD[STAR_N-1:0];
			star_src_r <= STSP_RST_WORD[STAR_N-1:0];
			star_val_r <= STSP_RST_WORD[STAR_N-1:0];
			star_inv_r <= STSP_RST_WORD[STAR_N-1:0];
		end else if (bus_req.wr) begin
			if (wr_star_en) begin
				star_en_r <= bus_req.wdata[STAR_N-1:0];
			end
			if (bus_req.addr == STSP_OFF_STAR_SRC) begin
				star_src_r <= bus_req.wdata[STAR_N-1:0];
			end
			if (bus_req.addr == STSP_OFF_STAR_VAL) begin
				star_val_r <= bus_req.wdata[STAR_N-1:0];
			end
			if (bus_req.addr == STSP_OFF_STAR_INV) begin
				star_inv_r <= bus_req.wdata[STAR_N-1:0];
			end
		end
	end

	// ----------------------------------------
	// Star trigger drive
	// ----------------------------------------
	logic [STAR_N-1:0] lane_mask;
	logic [STAR_N-1:0] star_drive;

	// An instrument module owns only its own pair, lane 0
	assign lane_mask  = role_sys_r ? {STAR_N{1'b1}} : {{(STAR_N-1){1'b0}}, 1'b1};
	// Contention is avoided by host ownership, not checked here
	assign star_drive = star_auth_s & star_en_r & lane_mask;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			star_trigger_pair_oe_n <= {STAR_N{1'b1}};
			star_trigger_pair_out  <= '0;
		end else begin
			star_trigger_pair_oe_n <= ~star_drive;
			star_trigger_pair_out  <= (star_src_r & trig_star_src) | (~star_src_r & star_val_r);
		end
	end

	// ----------------------------------------
	// Star trigger receive
	// ----------------------------------------
	logic [STAR_N-1:0] star_rx_nxt;

	// Sensed regardless of own drive, so loop-back is visible
	assign star_rx_nxt = star_in_s ^ star_inv_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			star_rx      <= '0;
			star_rx_rise <= '0;
		end else begin
			star_rx      <= star_rx_nxt;
			star_rx_rise <= star_rx_nxt & ~star_rx;
		end
	end

	// ----------------------------------------
	// Reference clock edges and activity
	// ----------------------------------------
	logic                      ref_d_r;
	logic                      ref_rise;
	logic [STSP_REF_CNT_W-1:0] ref_idle_r;
	logic                      ref_alive;

	assign ref_rise  = ref_s & ~ref_d_r;
	// Sampled reference only proves activity, not the 100 ppm accuracy
	assign ref_alive = ref_idle_r < STSP_REF_CNT_W'(STSP_REF_LOSS_CYC);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ref_d_r    <= 1'b0;
			ref_idle_r <= STSP_REF_CNT_W'(STSP_REF_LOSS_CYC);
		end else begin
			ref_d_r <= ref_s;
			if (ref_rise) begin
				ref_idle_r <= '0;
			end else if (ref_alive) begin
				ref_idle_r <= ref_idle_r + STSP_REF_CNT_W'(1);
			end
		end
	end

	// ----------------------------------------
	// Sync line drive
	// ----------------------------------------
	logic sync_src;
	logic sync_drive;

	assign sync_src   = sync_cfg_r.src_int ? trig_sync_src : sync_cfg_r.sw_val;
	assign sync_drive = role_sys_r & sync_auth_s & sync_cfg_r.drv_en;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sync_line_oe_n <= 1'b1;
		end else begin
			sync_line_oe_n <= ~sync_drive;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sync_line_out <= 1'b0;
		end else if (sync_cfg_r.mode == STSP_MODE_ASYNC) begin
			sync_line_out <= sync_src;
		end else if (ref_rise) begin
			// Launched on the sampled edge, so it holds for a whole period
			sync_line_out <= sync_src;
		end
	end

	// ----------------------------------------
	// Sync line receive
	// ----------------------------------------
	logic sync_rx_nxt;
	logic sync_rx_val;

	assign sync_rx_val = sync_in_s ^ sync_cfg_r.rx_inv;
	assign sync_rx_nxt = (sync_cfg_r.mode == STSP_MODE_SYNC && !ref_rise) ? sync_rx :
		sync_rx_val;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sync_rx      <= 1'b0;
			sync_rx_rise <= 1'b0;
		end else begin
			sync_rx      <= sync_rx_nxt;
			sync_rx_rise <= sync_rx_nxt & ~sync_rx;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [STSP_DATA_W-1:0] rd_word;

	always_comb begin
		rd_word = '0;
		unique case (bus_req.addr)
			STSP_OFF_CTRL: begin
				rd_word[STSP_CTRL_DRV_EN]  = sync_cfg_r.drv_en;
				rd_word[STSP_CTRL_MODE]    = sync_cfg_r.mode;
				rd_word[STSP_CTRL_SRC_INT] = sync_cfg_r.src_int;
				rd_word[STSP_CTRL_SW_VAL]  = sync_cfg_r.sw_val;
				rd_word[STSP_CTRL_RX_INV]  = sync_cfg_r.rx_inv;
			end
			STSP_OFF_STAR_EN:  rd_word[STAR_N-1:0] = star_en_r;
			STSP_OFF_STAR_SRC: rd_word[STAR_N-1:0] = star_src_r;
			STSP_OFF_STAR_VAL: rd_word[STAR_N-1:0] = star_val_r;
			STSP_OFF_STAR_INV: rd_word[STAR_N-1:0] = star_inv_r;
			STSP_OFF_STAR_RX:  rd_word[STAR_N-1:0] = star_rx;
			STSP_OFF_STAR_ACT: rd_word[STAR_N-1:0] = ~star_trigger_pair_oe_n;
			STSP_OFF_STATUS: begin
				rd_word[STSP_ST_SYNC_RX]   = sync_rx;
				rd_word[STSP_ST_SYNC_ACT]  = ~sync_line_oe_n;
				rd_word[STSP_ST_ROLE_SYS]  = role_sys_r;
				rd_word[STSP_ST_REF_ALIVE] = ref_alive;
				rd_word[STSP_ST_SYNC_AUTH] = sync_auth_s;
			end
			default: rd_word = '0;
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bus_rdata <= '0;
		end else if (bus_req.rd) begin
			bus_rdata <= rd_word;
		end else begin
			bus_rdata <= '0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	AST_STAR_OFF_AFTER_RESET: assert property (
		$past(sys_rst) |-> (&star_trigger_pair_oe_n))
		else $error("Star driver on right after reset");
	AST_STAR_NEEDS_BOTH: assert property (
		((~star_trigger_pair_oe_n) & ~$past(star_auth_s & star_en_r)) == '0)
		else $error("Star driver on without auth and host enable");
	AST_STAR_SW_DISABLE: assert property (
		(wr_star_en && bus_req.wdata[STAR_N-1:0] == '0) |-> ##2 (&star_trigger_pair_oe_n))
		else $error("Star driver still on after host disable");
	AST_SYNC_INSTR_NO_DRIVE: assert property (
		!role_sys_r |=> sync_line_oe_n)
		else $error("Instrument module drives sync line");
	AST_SYNC_NEEDS_AUTH: assert property (
		!sync_auth_s |=> sync_line_oe_n)
		else $error("Sync driver on without shelf authorisation");
	AST_SYNC_SW_DISABLE: assert property (
		(wr_ctrl && !bus_req.wdata[STSP_CTRL_DRV_EN]) |-> ##2 sync_line_oe_n)
		else $error("Sync driver still on after disable");
	AST_SYNC_MODE_HOLD: assert property (
		(sync_cfg_r.mode == STSP_MODE_SYNC && !ref_rise) |=> $stable(sync_line_out))
		else $error("Sync output moved between reference edges");
	AST_SYNC_ASYNC_FOLLOW: assert property (
		(sync_cfg_r.mode == STSP_MODE_ASYNC) |=> (sync_line_out == $past(sync_src)))
		else $error("Async sync output does not follow source");
	AST_STAR_RX_SENSE: assert property (
		##1 (star_rx == $past(star_in_s ^ star_inv_r)))
		else $error("Star receive sense wrong");
	AST_SYNC_RX_SENSE: assert property (
		(sync_cfg_r.mode == STSP_MODE_ASYNC) |=> (sync_rx == $past(sync_in_s ^ sync_cfg_r.rx_inv)))
		else $error("Sync receive sense wrong");

	COV_STAR_DRIVING: cover property (!star_trigger_pair_oe_n[0] ##1 star_rx_rise[0]);
	COV_SYNC_ALIGNED: cover property (!sync_line_oe_n && sync_cfg_r.mode == STSP_MODE_SYNC && ref_rise);
	COV_SYNC_RX_RISE: cover property (sync_rx_rise);

endmodule
`default_nettype wire

// [core/stsp_pkg.sv]
// Constants and types for the star-trigger and sync port controller
package stsp_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int STSP_STAR_CH  = 13;
	localparam int STSP_DATA_W   = 32;
	localparam int STSP_ADDR_W   = 8;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [STSP_ADDR_W-1:0] STSP_OFF_CTRL     = 8'h00;
	localparam logic [STSP_ADDR_W-1:0] STSP_OFF_STAR_EN  = 8'h04;
	localparam logic [STSP_ADDR_W-1:0] STSP_OFF_STAR_SRC = 8'h08;
	localparam logic [STSP_ADDR_W-1:0] STSP_OFF_STAR_VAL = 8'h0c;
	localparam logic [STSP_ADDR_W-1:0] STSP_OFF_STAR_INV = 8'h10;
	localparam logic [STSP_ADDR_W-1:0] STSP_OFF_STAR_RX  = 8'h14;
	localparam logic [STSP_ADDR_W-1:0] STSP_OFF_STAR_ACT = 8'h18;
	localparam logic [STSP_ADDR_W-1:0] STSP_OFF_STATUS   = 8'h1c;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int STSP_CTRL_DRV_EN  = 0;
	localparam int STSP_CTRL_MODE    = 1;
	localparam int STSP_CTRL_SRC_INT = 2;
	localparam int STSP_CTRL_SW_VAL  = 3;
	localparam int STSP_CTRL_RX_INV  = 4;
	localparam int STSP_ST_SYNC_RX   = 0;
	localparam int STSP_ST_SYNC_ACT  = 1;
	localparam int STSP_ST_ROLE_SYS  = 2;
	localparam int STSP_ST_REF_ALIVE = 3;
	localparam int STSP_ST_SYNC_AUTH = 4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [STSP_DATA_W-1:0] STSP_RST_WORD = 32'h0000_0000;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int STSP_SYS_CLK_NS  = 10;
	localparam int STSP_REF_FREQ_HZ = 100_000_000;
	localparam int STSP_REF_TOL_PPM = 100;
	localparam int STSP_REF_LOSS_NS = 640;
	localparam int STSP_REF_LOSS_CYC = STSP_REF_LOSS_NS / STSP_SYS_CLK_NS;
	localparam int STSP_REF_CNT_W   = 8;
	localparam int STSP_STRAP_SETTLE = 3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic {STSP_MODE_ASYNC, STSP_MODE_SYNC} stsp_sync_mode_t;

	typedef struct packed {
		logic [STSP_ADDR_W-1:0] addr;
		logic [STSP_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} stsp_bus_req_t;

	typedef struct packed {
		logic            drv_en;
		stsp_sync_mode_t mode;
		logic            src_int;
		logic            sw_val;
		logic            rx_inv;
	} stsp_sync_cfg_t;

endpackage

// [test/stsp_peer_model.sv]
// Backplane peer model: the other modules' star and sync trigger logic
`timescale 1ns/10ps
`default_nettype none
module stsp_peer_model
	import stsp_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire logic                    instr_ref_clock,
	input  wire logic [STSP_STAR_CH-1:0] grant,
	input  wire logic [STSP_STAR_CH-1:0] peer_val,
	input  wire logic                    peer_sync,
	input  wire logic [STSP_STAR_CH-1:0] dev_out,
	input  wire logic [STSP_STAR_CH-1:0] dev_oe_n,
	input  wire logic                    sync_out,
	input  wire logic                    sync_oe_n,
	output logic      [STSP_STAR_CH-1:0] star_line,
	output logic                         sync_line,
	output logic                         sync_seen
);
	logic alt_r = 1'b0;

	// Undriven pairs wander so a stale value never passes
	always_ff @(posedge sys_clk) begin
		alt_r <= ~alt_r;
	end

	// Peer drives only the lanes that the host granted it
	always_comb begin
		for (int i = 0; i < STSP_STAR_CH; i++) begin
			star_line[i] = !dev_oe_n[i] ? dev_out[i] : grant[i] ? peer_val[i] : alt_r ^ i[0];
		end
	end

	assign sync_line = !sync_oe_n ? sync_out : peer_sync;

	// Receiver samples the sync line on the reference rising edge
	always_ff @(posedge instr_ref_clock) begin
		sync_seen <= sync_line;
	end
endmodule
`default_nettype wire

// [test/stsp_ctrl_tb_top.sv]
// Self-checking bench for the star-trigger and sync port controller
`timescale 1ns/10ps
`default_nettype none
module stsp_ctrl_tb_top;
	import stsp_pkg::*;
	typedef struct {logic [12:0] auth, en, inv, pval, exp_oe_n, exp_rx;} stsp_row_t;

	logic          sys_clk = 1'b0;
	logic          sys_rst = 1'b1;
	logic          ref_clk = 1'b0;
	stsp_bus_req_t bus_req = '0;
	logic [31:0]   bus_rdata;
	logic          role = 1'b1;
	logic [12:0]   star_auth = '0, star_in, star_out, star_oe_n, star_src = '0;
	logic [12:0]   star_rx, star_rise, grant = 13'h1fff, peer_val = '0;
	logic          sync_auth = 1'b0, sync_in, sync_out, sync_oe_n, sync_src = 1'b0;
	logic          sync_rx, sync_rise, peer_sync = 1'b0, sync_seen;
	int            miscompares = 0;
	int            n_compared = 0;
	stsp_row_t     rows [4] = '{
		'{13'h0000, 13'h1fff, 13'h0000, 13'h1555, 13'h1fff, 13'h1555},
		'{13'h1fff, 13'h0000, 13'h1fff, 13'h0f0f, 13'h1fff, 13'h10f0},
		'{13'h1fff, 13'h0aaa, 13'h0000, 13'h1fff, 13'h1555, 13'h1555},
		'{13'h0f0f, 13'h1fff, 13'h00ff, 13'h1fff, 13'h10f0, 13'h100f}};

	always #5 sys_clk = ~sys_clk;

	// Reference clock sits 3 ns off the system clock edges, period 16 system cycles
	initial begin
		#3;
		forever #80 ref_clk = ~ref_clk;
	end

	stsp_ctrl i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .role_system_strap(role), .shelf_star_auth(star_auth),
		.shelf_sync_auth(sync_auth), .star_trigger_pair_in(star_in),
		.star_trigger_pair_out(star_out), .star_trigger_pair_oe_n(star_oe_n),
		.sync_line_in(sync_in), .sync_line_out(sync_out), .sync_line_oe_n(sync_oe_n),
		.instr_ref_clock(ref_clk), .trig_star_src(star_src), .trig_sync_src(sync_src),
		.star_rx(star_rx), .star_rx_rise(star_rise), .sync_rx(sync_rx),
		.sync_rx_rise(sync_rise));

	stsp_peer_model i_peer (.sys_clk(sys_clk), .instr_ref_clock(ref_clk), .grant(grant),
		.peer_val(peer_val), .peer_sync(peer_sync), .dev_out(star_out), .dev_oe_n(star_oe_n),
		.sync_out(sync_out), .sync_oe_n(sync_oe_n), .star_line(star_in),
		.sync_line(sync_in), .sync_seen(sync_seen));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic close_out();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		chk(nm, exp, bus_rdata);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		tick(10);
		sys_rst <= 1'b0;
		tick(4);
		chk("star_oe_n", 32'h1fff, {19'h0, star_oe_n});
		chk("sync_oe_n", 32'h1, {31'h0, sync_oe_n});
		for (int a = 0; a < 5; a++) begin
			bus_rd(8'(a * 4), STSP_RST_WORD, "reset word");
		end
		foreach (rows[k]) begin
			@(posedge sys_clk);
			star_auth <= rows[k].auth;
			peer_val <= rows[k].pval;
			grant <= rows[k].exp_oe_n;
			bus_wr(STSP_OFF_STAR_EN, {19'h0, rows[k].en});
			bus_wr(STSP_OFF_STAR_INV, {19'h0, rows[k].inv});
			tick(6);
			chk("star_oe_n", {19'h0, rows[k].exp_oe_n}, {19'h0, star_oe_n});
			chk("star_rx", {19'h0, rows[k].exp_rx}, {19'h0, star_rx});
			bus_rd(STSP_OFF_STAR_ACT, {19'h0, ~rows[k].exp_oe_n}, "star_act");
		end
		// Auth drop cuts the driver 3 cycles later, host disable 1 cycle after the write
		@(posedge sys_clk);
		star_auth <= 13'h1fff;
		bus_wr(STSP_OFF_STAR_EN, 32'h1fff);
		bus_wr(STSP_OFF_STAR_VAL, 32'h1234);
		tick(6);
		chk("star_out val", 32'h1234, {19'h0, star_out});
		@(posedge sys_clk);
		star_src <= 13'h0abc;
		bus_wr(STSP_OFF_STAR_SRC, 32'h1fff);
		tick(3);
		chk("star_out src", 32'h0abc, {19'h0, star_out});
		@(posedge sys_clk);
		star_auth <= 13'h0001;
		tick(3);
		chk("oe_n auth drop", 32'h1ffe, {19'h0, star_oe_n});
		bus_wr(STSP_OFF_STAR_EN, 32'h0);
		tick(1);
		chk("oe_n host off", 32'h1fff, {19'h0, star_oe_n});
		// Sync driver needs shelf authorisation
		bus_wr(STSP_OFF_CTRL, 32'h05);
		tick(6);
		chk("sync_oe_n no auth", 32'h1, {31'h0, sync_oe_n});
		bus_rd(STSP_OFF_CTRL, 32'h05, "ctrl");
		@(posedge sys_clk);
		sync_auth <= 1'b1;
		sync_src <= 1'b1;
		tick(6);
		chk("sync_oe_n auth", 32'h0, {31'h0, sync_oe_n});
		chk("sync_out async", 32'h1, {31'h0, sync_out});
		bus_rd(STSP_OFF_STATUS, 32'h1f, "status");
		// Aligned mode holds the line between reference edges
		bus_wr(STSP_OFF_CTRL, 32'h07);
		@(posedge ref_clk);
		tick(5);
		@(posedge sys_clk);
		sync_src <= 1'b0;
		tick(7);
		chk("sync_out hold", 32'h1, {31'h0, sync_out});
		@(posedge ref_clk);
		tick(4);
		chk("sync_out edge", 32'h0, {31'h0, sync_out});
		@(posedge ref_clk);
		tick(1);
		chk("sync seen", 32'h0, {31'h0, sync_seen});
		bus_wr(STSP_OFF_CTRL, 32'h18);
		@(posedge sys_clk);
		peer_sync <= 1'b1;
		tick(6);
		chk("sync_oe_n off", 32'h1, {31'h0, sync_oe_n});
		chk("sync_rx inv", 32'h0, {31'h0, sync_rx});
		chk("sync_out sw", 32'h1, {31'h0, sync_out});
		bus_wr(STSP_OFF_CTRL, 32'h0);
		tick(1);
		chk("sync_rx_rise", 32'h1, {31'h0, sync_rise});
		tick(1);
		chk("sync_rx_rise end", 32'h0, {31'h0, sync_rise});
		tick(4);
		chk("sync_rx", 32'h1, {31'h0, sync_rx});
		bus_wr(8'h24, 32'hffff_ffff);
		bus_rd(8'h20, 32'h0, "unmapped");
		bus_rd(STSP_OFF_CTRL, 32'h0, "ctrl after unmapped");
		// Instrument role: lane 0 only, sync never driven
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		role <= 1'b0;
		grant <= 13'h1ffe;
		tick(2);
		chk("oe_n in reset", 32'h1fff, {19'h0, star_oe_n});
		@(posedge sys_clk);
		sys_rst <= 1'b0;
		star_auth <= 13'h1fff;
		bus_wr(STSP_OFF_STAR_EN, 32'h1fff);
		bus_wr(STSP_OFF_CTRL, 32'h05);
		tick(6);
		chk("instr star oe_n", 32'h1ffe, {19'h0, star_oe_n});
		chk("instr sync oe_n", 32'h1, {31'h0, sync_oe_n});
		// Peer pulses its granted lanes; lane 0 stays low under own drive
		@(posedge sys_clk);
		peer_val <= 13'h0;
		tick(4);
		chk("star_rx low", 32'h0, {19'h0, star_rx});
		@(posedge sys_clk);
		peer_val <= 13'h1fff;
		tick(3);
		chk("star_rx_rise", 32'h1ffe, {19'h0, star_rise});
		tick(1);
		chk("star_rx_rise end", 32'h0, {19'h0, star_rise});
		close_out();
	end

	// Run needs a few hundred cycles; this cuts a hang short
	initial begin
		#100000;
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire
